// file: verilog/adcm_top.sv
// Converter control: input and reference selection, timing, threshold monitor
`timescale 1ns/1ps
`include "adcm_params.svh"

module adcm_top
	import adcm_pkg::*;
(
	input  wire logic        sys_clk,      // System clock, 250 MHz
	input  wire logic        rst,          // Synchronous reset, active high
	input  wire logic [7:0]  reg_addr,     // Register byte address
	input  wire logic [31:0] reg_wdata,    // Write data
	input  wire logic        reg_wr,       // Write strobe
	input  wire logic        reg_rd,       // Read strobe
	output logic      [31:0] reg_rdata,    // Read data, cycle after strobe
	output logic      [2:0]  ain_sel,      // Analogue input mux select
	output logic      [1:0]  refp_sel,     // Upper reference select
	output logic             refn_sel,     // Lower reference select, 1 = pin
	output logic             sample_req,   // Pulse: sample and convert now
	input  wire logic        conv_ready,   // Core result valid (async)
	input  wire logic [11:0] conv_code,    // Core result code, MSB aligned
	output logic             irq,          // Level interrupt
	output logic             done_pulse    // Pulse per completed result
);
	// ======================================================================
	// Registers
	logic [8:0]  ctrl_reg;
	logic [11:0] lo_th_reg;
	logic [11:0] hi_th_reg;
	logic [11:0] result_reg;
	logic [2:0]  stat_reg;
	logic [2:0]  mask_reg;
	logic [2:0]  stat_next;
	logic [31:0] rdata_next;
	logic [21:0] tmr_reg;
	logic        rdy_s1_reg;
	logic        rdy_s2_reg;
	logic        rdy_s3_reg;
	logic        one_shot_reg;
	logic        start_pend_reg;
	adcm_state_e state_reg;

	// Address decode
	wire wr_ctrl  = reg_wr && reg_addr == `ADCM_CTRL_OFS;
	wire wr_start = reg_wr && reg_addr == `ADCM_START_OFS;
	wire wr_lo    = reg_wr && reg_addr == `ADCM_LOTH_OFS;
	wire wr_hi    = reg_wr && reg_addr == `ADCM_HITH_OFS;
	wire wr_stat  = reg_wr && reg_addr == `ADCM_STAT_OFS;
	wire wr_mask  = reg_wr && reg_addr == `ADCM_MASK_OFS;

	// Field views
	wire [2:0] insel_f = ctrl_reg[`ADCM_CTRL_INSEL_LSB +: 3];
	wire [1:0] refp_f  = ctrl_reg[`ADCM_CTRL_REFP_LSB +: 2];
	wire       res12   = ctrl_reg[`ADCM_CTRL_RES_BIT];
	wire       cont    = ctrl_reg[`ADCM_CTRL_CONT_BIT];
	wire       enable  = ctrl_reg[`ADCM_CTRL_EN_BIT];

	// five inputs: out-of-range codes fall back to the first pin
	wire [2:0] insel_ok = (insel_f > 3'(ADCM_IN_BG)) ? 3'(ADCM_IN_P37) : insel_f;
	// three sources: spare code maps to supply
	wire [1:0] refp_ok  = (refp_f > 2'(ADCM_RP_VDD)) ? 2'(ADCM_RP_VDD) : refp_f;

	// result width: 8-bit mode truncates the MSB aligned code
	wire [11:0] code_w = res12 ? conv_code : {conv_code[11:4], 4'h0};
	wire        rdy_rise = rdy_s2_reg && !rdy_s3_reg;
	// code is already ratio to span; store it unscaled
	wire [11:0] new_res = code_w;
	// threshold compares on each fresh result
	wire        below = new_res < lo_th_reg;
	wire        above = new_res > hi_th_reg;

	// period per resolution, rounded down to whole cycles
	wire [21:0] period = res12 ? 22'(`ADCM_PERIOD12_CYC) : 22'(`ADCM_PERIOD8_CYC);

	// sticky flags: set wins over write-one clear
	always_comb begin
		stat_next = stat_reg & ~(wr_stat ? reg_wdata[2:0] : 3'h0);
		if (rdy_rise && state_reg == ADCM_CONV) begin
			stat_next[`ADCM_ST_DONE] = 1'b1;
			stat_next[`ADCM_ST_LOW]  = stat_next[`ADCM_ST_LOW] | below;
			stat_next[`ADCM_ST_HIGH] = stat_next[`ADCM_ST_HIGH] | above;
		end
	end

	// Read mux
	always_comb begin
		case (reg_addr)
			`ADCM_CTRL_OFS:   rdata_next = {23'h0, ctrl_reg};
			`ADCM_START_OFS:  rdata_next = {31'h0, state_reg != ADCM_IDLE};
			`ADCM_RESULT_OFS: rdata_next = {20'h0, result_reg};
			`ADCM_LOTH_OFS:   rdata_next = {20'h0, lo_th_reg};
			`ADCM_HITH_OFS:   rdata_next = {20'h0, hi_th_reg};
			`ADCM_STAT_OFS:   rdata_next = {29'h0, stat_reg};
			`ADCM_MASK_OFS:   rdata_next = {29'h0, mask_reg};
			// vector and priority readable for the interrupt router
			`ADCM_INFO_OFS:   rdata_next = {24'h0, `ADCM_IRQ_PRIORITY, `ADCM_IRQ_VECTOR};
			default:          rdata_next = 32'h0;
		endcase
	end

	// Register writes and read data
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_reg  <= 9'h0;
			lo_th_reg <= `ADCM_TH_LO_RST;
			hi_th_reg <= `ADCM_TH_HI_RST;
			mask_reg  <= 3'h0;
			stat_reg  <= 3'h0;
			reg_rdata <= 32'h0;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= reg_wdata[8:0];
			if (wr_lo)
				lo_th_reg <= reg_wdata[11:0];
			if (wr_hi)
				hi_th_reg <= reg_wdata[11:0];
			if (wr_mask)
				mask_reg <= reg_wdata[2:0];
			stat_reg  <= stat_next;
			reg_rdata <= reg_rd ? rdata_next : 32'h0;
		end
	end

	// Ready synchroniser; stages two and three feed the edge detector
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdy_s1_reg <= 1'b0;
			rdy_s2_reg <= 1'b0;
			rdy_s3_reg <= 1'b0;
		end else begin
			rdy_s1_reg <= conv_ready;
			rdy_s2_reg <= rdy_s1_reg;
			rdy_s3_reg <= rdy_s2_reg;
		end
	end

	// Conversion sequencer; mux settings frozen while a sample runs
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg      <= ADCM_IDLE;
			tmr_reg        <= 22'h0;
			sample_req     <= 1'b0;
			done_pulse     <= 1'b0;
			result_reg     <= 12'h0;
			ain_sel        <= 3'h0;
			refp_sel       <= 2'h0;
			refn_sel       <= 1'b0;
			start_pend_reg <= 1'b0;
			one_shot_reg   <= 1'b0;
		end else begin
			sample_req <= 1'b0;
			done_pulse <= 1'b0;
			if (wr_start)
				start_pend_reg <= 1'b1;
			if (state_reg != ADCM_IDLE)
				tmr_reg <= tmr_reg + 22'h1;
			case (state_reg)
				ADCM_IDLE: begin
					if (enable && (cont || start_pend_reg || wr_start)) begin
						ain_sel        <= insel_ok;
						// reference pair; battery monitor needs no extra path
						refp_sel       <= refp_ok;
						refn_sel       <= ctrl_reg[`ADCM_CTRL_REFN_BIT];
						sample_req     <= 1'b1;
						tmr_reg        <= 22'h0;
						one_shot_reg   <= !cont;
						start_pend_reg <= 1'b0;
						state_reg      <= ADCM_CONV;
					end
				end
				ADCM_CONV: begin
					if (rdy_rise) begin
						result_reg <= new_res;
						done_pulse <= 1'b1;
						state_reg  <= ADCM_WAIT;
					end
				end
				ADCM_WAIT: begin
					// continuous pacing; single shot returns at once
					// Leave one cycle early: the idle pass costs a cycle before the next pulse
					if (one_shot_reg || !enable || !cont || tmr_reg >= period - 22'h2)
						state_reg <= ADCM_IDLE;
				end
				default: state_reg <= ADCM_IDLE;
			endcase
		end
	end

	// Interrupt level, registered
	always_ff @(posedge sys_clk) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(stat_next & mask_reg);
	end
endmodule

// file: common/adcm_params.svh
// Constants for the converter control block: offsets, fields, resets and timing
`ifndef ADCM_PARAMS_SVH
`define ADCM_PARAMS_SVH

// ==========================================================================
// Register offsets
`define ADCM_CTRL_OFS   8'h00
`define ADCM_START_OFS  8'h04
`define ADCM_RESULT_OFS 8'h08
`define ADCM_LOTH_OFS   8'h0c
`define ADCM_HITH_OFS   8'h10
`define ADCM_STAT_OFS   8'h14
`define ADCM_MASK_OFS   8'h18
`define ADCM_INFO_OFS   8'h1c

// ==========================================================================
// Control fields
`define ADCM_CTRL_INSEL_LSB 0
`define ADCM_CTRL_REFP_LSB  3
`define ADCM_CTRL_REFN_BIT  5
`define ADCM_CTRL_RES_BIT   6
`define ADCM_CTRL_CONT_BIT  7
`define ADCM_CTRL_EN_BIT    8
`define ADCM_CTRL_RST       32'h0000_0000
`define ADCM_TH_LO_RST      12'h000
`define ADCM_TH_HI_RST      12'hfff

// Status bits
`define ADCM_ST_DONE 0
`define ADCM_ST_LOW  1
`define ADCM_ST_HIGH 2

// Interrupt identity
`define ADCM_IRQ_VECTOR   4'h8
`define ADCM_IRQ_PRIORITY 4'h9

// ==========================================================================
// Timing
`define ADCM_CLK_HZ      250000000
`define ADCM_RATE8_HZ    20000
`define ADCM_RATE12_HZ   10000
`define ADCM_PERIOD8_CYC  (`ADCM_CLK_HZ / `ADCM_RATE8_HZ)
`define ADCM_PERIOD12_CYC (`ADCM_CLK_HZ / `ADCM_RATE12_HZ)

`endif

// file: common/adcm_pkg.sv
// Types shared by the converter control block
package adcm_pkg;
	typedef enum logic [2:0] {
		ADCM_IN_P37, ADCM_IN_P36, ADCM_IN_P35, ADCM_IN_P34, ADCM_IN_BG
	} adcm_insel_e;
	typedef enum logic [1:0] {ADCM_RP_P37, ADCM_RP_BG, ADCM_RP_VDD} adcm_refp_e;
	typedef enum {ADCM_IDLE, ADCM_CONV, ADCM_WAIT} adcm_state_e;
endpackage

// file: tb/adcm_asserts.sv
// Port checks for the converter control block
`timescale 1ns/1ps

module adcm_asserts (
	input wire logic        sys_clk,    // Clock
	input wire logic        rst,        // Sync reset
	input wire logic        reg_wr,     // Write strobe
	input wire logic        reg_rd,     // Read strobe
	input wire logic [31:0] reg_rdata,  // Read data
	input wire logic [2:0]  ain_sel,    // Input select
	input wire logic [1:0]  refp_sel,   // Upper reference
	input wire logic        sample_req, // Start pulse
	input wire logic        conv_ready, // Core valid
	input wire logic        irq,        // Interrupt
	input wire logic        done_pulse  // Result pulse
);
	// ==========================================================
	// Properties
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Core result must be stored two to four cycles after ready rises
	sequence s_ready;
		$rose(conv_ready);
	endsequence
	sequence s_stored;
		##[2:4] done_pulse;
	endsequence
	a_req_spaced: assert property (sample_req |=> !sample_req [*8])
		else $error("start pulse repeated too soon");
	a_done_single: assert property (done_pulse |=> !done_pulse)
		else $error("done pulse longer than one cycle");
	a_done_delay: assert property (s_ready |-> s_stored)
		else $error("result not stored after core ready");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	a_insel_range: assert property (ain_sel <= 3'h4)
		else $error("input select out of range");
	a_refp_range: assert property (refp_sel != 2'h3)
		else $error("upper reference code illegal");
	a_irq_quiet: assert property ($past(rst) |-> !irq)
		else $error("interrupt high after reset");
	// Falling interrupt needs a write to stat or mask just before
	a_irq_sticky: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
		else $error("interrupt dropped with no write");
endmodule

// file: tb/adcm_core_model.sv
// Analogue core stand-in: answers a start pulse with a code
`timescale 1ns/1ps

module adcm_core_model (
	input wire logic        sys_clk,    // Clock
	input wire logic        sample_req, // Start pulse
	input wire logic [2:0]  ain_sel,    // Input select
	output logic            conv_ready, // Result valid
	output logic     [11:0] conv_code   // Result code
);
	// Code depends on input so a wrong select shows up
	initial begin
		conv_ready = 1'b0;
		conv_code = 12'hfff;
	end
	always @(posedge sys_clk) begin
		if (sample_req === 1'b1) begin
			repeat (20) @(posedge sys_clk);
			conv_code <= {ain_sel, 9'h0a5};
			conv_ready <= 1'b1;
			repeat (4) @(posedge sys_clk);
			conv_ready <= 1'b0;
			// Released code must not look valid
			conv_code <= ~conv_code;
		end
	end
endmodule

// file: tb/tb_adcm_top.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`include "adcm_params.svh"

module tb_adcm_top;
	import adcm_pkg::*;
	logic        sys_clk, rst, reg_wr, reg_rd, sample_req, conv_ready, irq, done_pulse, refn_sel;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [2:0]  ain_sel;
	logic [1:0]  refp_sel;
	logic [11:0] conv_code;
	int          n_mismatch, check_count, n;
	adcm_top adcm_top_inst (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.ain_sel, .refp_sel, .refn_sel, .sample_req, .conv_ready, .conv_code, .irq, .done_pulse);
	adcm_core_model adcm_core_model_inst (.sys_clk, .sample_req, .ain_sel, .conv_ready, .conv_code);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// ==========================================================
	// Bus and compare tasks
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Wait bounded for the next sample pulse, n counts cycles
	task seek;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (sample_req !== 1'b1 && n < 30000);
	endtask
	task conv(input logic [31:0] c);
		wr(`ADCM_CTRL_OFS, c);
		wr(`ADCM_START_OFS, 32'h1);
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (done_pulse !== 1'b1 && n < 200);
		chk(n < 200, 1);
	endtask
	// ==========================================================
	// Scenarios
	task t_regs;
		rd(`ADCM_LOTH_OFS);
		chk(d, `ADCM_TH_LO_RST);
		rd(`ADCM_HITH_OFS);
		chk(d, `ADCM_TH_HI_RST);
		rd(`ADCM_INFO_OFS);
		chk(d, {`ADCM_IRQ_PRIORITY, `ADCM_IRQ_VECTOR});
		wr(8'h20, 32'h1ff);
		rd(8'h20);
		chk(d, 0);
		rd(`ADCM_CTRL_OFS);
		chk(d, `ADCM_CTRL_RST);
		$display("regs test end");
	endtask
	// Every input, reference and both resolutions
	task t_sel;
		for (int i = 0; i < 5; i++) begin
			conv(32'h100 | i | (i % 3) << 3 | (i & 1) << 5 | (i & 1) << 6);
			chk(ain_sel, i);
			chk(refp_sel, i % 3);
			chk(refn_sel, i & 1);
			rd(`ADCM_RESULT_OFS);
			chk(d, (i << 9 | 12'h0a5) & ((i & 1) ? 12'hfff : 12'hff0));
			rd(`ADCM_STAT_OFS);
			chk(d, 32'h1);
			wr(`ADCM_STAT_OFS, 32'h1);
		end
		$display("select test end");
	endtask
	// Code 0x4a5 sits below low and above high at once
	task t_irq;
		wr(`ADCM_LOTH_OFS, 32'h600);
		wr(`ADCM_HITH_OFS, 32'h200);
		wr(`ADCM_MASK_OFS, 32'h4);
		conv(32'h142);
		rd(`ADCM_STAT_OFS);
		chk(d, 32'h7);
		chk(irq, 1);
		wr(`ADCM_MASK_OFS, 32'h0);
		rd(`ADCM_STAT_OFS);
		chk(irq, 0);
		wr(`ADCM_STAT_OFS, 32'h4);
		wr(`ADCM_MASK_OFS, 32'h6);
		rd(`ADCM_STAT_OFS);
		chk(d, 32'h3);
		chk(irq, 1);
		wr(`ADCM_STAT_OFS, 32'h3);
		rd(`ADCM_STAT_OFS);
		chk(d, 32'h0);
		chk(irq, 0);
		$display("irq test end");
	endtask
	task t_cont(input logic [31:0] c, input int per);
		// Enable with continuous set starts sampling by itself
		wr(`ADCM_CTRL_OFS, c);
		seek;
		seek;
		chk(n, per);
		wr(`ADCM_CTRL_OFS, 32'h0);
		repeat (60) @(posedge sys_clk);
		$display("continuous test end");
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 40'h0};
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_sel;
		t_irq;
		t_cont(32'h180, `ADCM_PERIOD8_CYC);
		t_cont(32'h1c0, `ADCM_PERIOD12_CYC);
		end_sim;
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_mismatch++;
		end_sim;
	end
endmodule

bind adcm_top adcm_asserts adcm_asserts_inst (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_rdata,
	.ain_sel, .refp_sel, .sample_req, .conv_ready, .irq, .done_pulse);
